//--- src/dpll_pkg.sv
// constants and types shared by the digital loop core
package dpll_pkg;
	localparam int                 DIV_W          = 16;
	localparam int                 FTW_W          = 32;
	localparam int                 ERR_W          = 24;
	localparam int                 COEF_W         = 16;
	localparam int                 ACC_W          = 48;
	localparam int                 EST_W          = 24;
	localparam int                 AVG_SHIFT      = 6;
	localparam int                 MISS_W         = 16;
	localparam logic [DIV_W-1:0]   DIV_RESET      = 16'h0000;
	localparam logic [FTW_W-1:0]   FTW_RESET      = 32'h0000_0000;
	localparam logic [EST_W-1:0]   EST_WINDOW     = 24'h01_0000;
	localparam logic [MISS_W-1:0]  MISS_LIMIT     = 16'h1000;
	localparam int                 DAC_W          = 14;

	typedef enum logic [3:0]
	{
		ST_IDLE    = 4'b0001,
		ST_ESTIM   = 4'b0010,
		ST_TRACK   = 4'b0100,
		ST_HOLD    = 4'b1000
	} loop_state_t;
endpackage : dpll_pkg

//--- src/edge_divider.sv
// programmable integer divider, stored value is ratio minus one, emits one-cycle tick
`timescale 1ns/100ps
module edge_divider
	import dpll_pkg::*;
(
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	input  wire logic             sig_in,
	input  wire logic [DIV_W-1:0] ratio_m1,
	output logic                  tick
);
	logic             sig_d;
	logic             armed;
	logic [DIV_W-1:0] count;

	// no edge until one real sample is held: a pin already high at reset release is not an edge
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sig_d <= 1'b0;
			armed <= 1'b0;
		end
		else
		begin
			sig_d <= sig_in;
			armed <= 1'b1;
		end
	end

	// stored zero divides by one
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			count <= '0;
			tick  <= 1'b0;
		end
		else
		begin
			tick <= 1'b0;
			if (sig_in && !sig_d && armed)
			begin
				if (count >= ratio_m1)
				begin
					count <= '0;
					tick  <= 1'b1;
				end
				else
					count <= count + 1'b1;
			end
		end
	end
endmodule : edge_divider

//--- src/digital_loop_core.sv
// digital loop core: dividers, phase detector, loop filter, dds, holdover and switchover
`timescale 1ns/100ps
// Functional notes
// RL1: output clock tracks phase and frequency of the active reference.
// RL2: manual and automatic holdover; output continues while system clock runs.
// RL3: holdover freezes tuning at averaged pre-holdover steady-state frequency word.
// RL4: manual and automatic reference switchover when reference suspect or lost; the core switches only on loss, it has no suspect check.
// RL5: configuring party keeps output at most 40% of sample rate, 50% absolute.
// RL6: selected reference divided by programmable R before detector.
// RL7: detector produces phase error words fed into the loop filter.
// RL8: loop filter response set only by programmable numeric coefficients.
// RL9: each loop filter output word drives the dds tuning input.
// RL10: oscillator is a dds with dac output, both on system clock.
// RL11: frequency estimator may be enabled or bypassed.
// RL12: estimator measures detector frequency with loop idle, loads tuning near estimate times S.
// RL13: after estimate the phase loop runs and holds lock.
// RL14: feedback divided by programmable S; locked oscillator runs S times detector rate.
// RL15: select pin input in manual mode, output in auto; low first, high second.
// RL16: holdover pin forces holdover in manual mode, reports it in auto mode.
// RL17: stored R field is ratio minus one.
// RL18: stored S field is ratio minus one.
// RL19: auto holdover when active reference lost without valid alternate; resume on restore.
// RL20: auto switchover changes detector input without resetting loop filter.
module digital_loop_core
(
	input  wire logic                         sys_clk,
	input  wire logic                         nrst,
	input  wire logic                         ref_input_first,
	input  wire logic                         ref_input_second,
	input  wire logic                         feedback_clock_input,
	input  wire logic                         reference_choice_pin_in,
	output logic                              reference_choice_pin_out,
	output logic                              reference_choice_pin_oe,
	input  wire logic                         holdover_pin_in,
	output logic                              holdover_pin_out,
	output logic                              holdover_pin_oe,
	input  wire logic                         auto_switch_mode,
	input  wire logic                         auto_holdover_mode,
	input  wire logic                         estimator_enable,
	input  wire logic [dpll_pkg::DIV_W-1:0]   r_div_m1,
	input  wire logic [dpll_pkg::DIV_W-1:0]   s_div_m1,
	input  wire logic [dpll_pkg::COEF_W-1:0]  coef_prop,
	input  wire logic [dpll_pkg::COEF_W-1:0]  coef_integ,
	input  wire logic [dpll_pkg::FTW_W-1:0]   ftw_nominal,
	output logic [dpll_pkg::FTW_W-1:0]        tuning_word,
	output logic [dpll_pkg::DAC_W-1:0]        dac_code,
	output logic                              in_holdover,
	output logic                              active_second,
	output logic                              first_lost,
	output logic                              second_lost,
	output logic                              phase_locked
);
	import dpll_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	logic                     sel;
	logic                     ref_mux;
	logic                     pfd_tick;
	logic                     fb_tick;
	logic                     tick_a;
	logic                     tick_b;
	logic [MISS_W-1:0]        miss_a;
	logic [MISS_W-1:0]        miss_b;
	logic                     lost_a;
	logic                     lost_b;
	logic                     hold_req;
	loop_state_t              state;
	logic signed [ERR_W-1:0]  phase_cnt;
	logic signed [ERR_W-1:0]  phase_err;
	logic                     err_valid;
	logic signed [ACC_W-1:0]  integ;
	logic signed [ACC_W-1:0]  next_filter;
	logic [FTW_W-1:0]         ftw_avg;
	logic [FTW_W-1:0]         ftw_base;
	logic [FTW_W-1:0]         phase_acc;
	logic [EST_W-1:0]         est_timer;
	logic [EST_W-1:0]         est_edges;
	logic [15:0]              lock_cnt;

	// selected reference; divider state is shared so a swap only changes the source
	assign ref_mux = sel ? ref_input_second : ref_input_first; // [RL20]

	edge_divider u_rdiv
	(
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.sig_in   (ref_mux),
		.ratio_m1 (r_div_m1),
		.tick     (pfd_tick)
	); // [RL6] [RL17]

	edge_divider u_sdiv
	(
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.sig_in   (feedback_clock_input),
		.ratio_m1 (s_div_m1),
		.tick     (fb_tick)
	); // [RL14] [RL18]

	edge_divider u_act_a
	(
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.sig_in   (ref_input_first),
		.ratio_m1 (DIV_RESET),
		.tick     (tick_a)
	);

	edge_divider u_act_b
	(
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.sig_in   (ref_input_second),
		.ratio_m1 (DIV_RESET),
		.tick     (tick_b)
	);

	////////////////////////////////////////////////////////////////////////////
	// loss monitors: no edge for MISS_LIMIT cycles declares a reference lost
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			miss_a <= '0;
			miss_b <= '0;
		end
		else
		begin
			miss_a <= tick_a ? '0 : (lost_a ? miss_a : miss_a + 1'b1);
			miss_b <= tick_b ? '0 : (lost_b ? miss_b : miss_b + 1'b1);
		end
	end
	assign lost_a = (miss_a >= MISS_LIMIT);
	assign lost_b = (miss_b >= MISS_LIMIT);

	// reference selection: pin in manual mode, loss-driven in auto mode
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			sel <= 1'b0;
		else if (!auto_switch_mode)
			sel <= reference_choice_pin_in; // [RL15] [RL4]
		else if (!sel && lost_a && !lost_b)
			sel <= 1'b1; // [RL4] [RL20]
		else if (sel && lost_b && !lost_a)
			sel <= 1'b0; // [RL4] [RL20]
	end

	// holdover request: pin in manual mode, loss of all usable references in auto
	assign hold_req = auto_holdover_mode ? (sel ? lost_b : lost_a) && (lost_a || !auto_switch_mode)
		&& (lost_b || !auto_switch_mode) : holdover_pin_in; // [RL16] [RL19]

	////////////////////////////////////////////////////////////////////////////
	// loop sequencing
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			state <= ST_IDLE;
		else
		begin
			unique case (state)
				ST_IDLE:  state <= hold_req ? ST_HOLD : (estimator_enable ? ST_ESTIM : ST_TRACK); // [RL11]
				ST_ESTIM: if (hold_req) state <= ST_HOLD;
				          else if (est_timer == EST_WINDOW) state <= ST_TRACK; // [RL13]
				ST_TRACK: if (hold_req) state <= ST_HOLD; // [RL2]
				ST_HOLD:  if (!hold_req) state <= ST_TRACK; // [RL19]
			endcase
		end
	end

	// estimator: count detector edges over a window with the loop idle
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			est_timer <= '0;
			est_edges <= '0;
		end
		else if (state == ST_ESTIM)
		begin
			est_timer <= est_timer + 1'b1;
			est_edges <= est_edges + {{(EST_W-1){1'b0}}, pfd_tick}; // [RL12]
		end
		else
		begin
			est_timer <= '0;
			est_edges <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// detector: signed count of reference ticks minus feedback ticks, cleared to zero when both tick in one cycle
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			phase_cnt <= '0;
			phase_err <= '0;
			err_valid <= 1'b0;
		end
		else
		begin
			err_valid <= pfd_tick | fb_tick;
			if (pfd_tick && fb_tick)
			begin
				phase_err <= phase_cnt;
				phase_cnt <= '0;
			end
			else if (pfd_tick)
			begin
				phase_err <= phase_cnt;
				phase_cnt <= phase_cnt + 1'b1;
			end
			else if (fb_tick)
			begin
				phase_err <= phase_cnt;
				phase_cnt <= phase_cnt - 1'b1;
			end
		end
	end // [RL7]

	// proportional plus integral filter from numeric coefficients
	assign next_filter = integ + ACC_W'(phase_err) * $signed({1'b0, coef_prop}); // [RL8]

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			integ <= '0;
		else if (state == ST_TRACK && err_valid)
			integ <= integ + ACC_W'(phase_err) * $signed({1'b0, coef_integ}); // [RL8] [RL20]
	end

	// estimate times S times window scale sets the base word; fixed point kept simple
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			ftw_base <= FTW_RESET;
		else if (state == ST_IDLE)
			ftw_base <= ftw_nominal;
		else if (state == ST_ESTIM && est_timer == EST_WINDOW)
			ftw_base <= FTW_W'((ACC_W'(est_edges) * (ACC_W'(s_div_m1) + 48'h0000_0000_0001))
				<< $clog2(EST_WINDOW)); // [RL12]
	end

	////////////////////////////////////////////////////////////////////////////
	// tuning word: filter output in tracking, running average frozen in holdover
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tuning_word <= FTW_RESET;
			ftw_avg     <= FTW_RESET;
		end
		else
		begin
			unique case (state)
				ST_TRACK:
				begin
					tuning_word <= ftw_base + FTW_W'(next_filter >>> COEF_W); // [RL9] [RL1] [RL13]
					ftw_avg     <= ftw_avg - (ftw_avg >> AVG_SHIFT) + (tuning_word >> AVG_SHIFT);
				end
				ST_HOLD:  tuning_word <= ftw_avg; // [RL3] [RL2]
				default:  tuning_word <= ftw_base;
			endcase
		end
	end

	// dds accumulator and dac code on the system clock
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			phase_acc <= '0;
			dac_code  <= '0;
		end
		else
		begin
			phase_acc <= phase_acc + tuning_word; // [RL10]
			dac_code  <= phase_acc[FTW_W-1 -: DAC_W]; // sawtooth; sine lookup lives in the analog path
		end
	end

	// lock flag: small errors for a while
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			lock_cnt <= '0;
		else if (state != ST_TRACK || phase_err > 24'sd2 || phase_err < -24'sd2)
			lock_cnt <= '0;
		else if (lock_cnt != 16'hFFFF)
			lock_cnt <= lock_cnt + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	// registered status and pin drivers
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			in_holdover              <= 1'b0;
			active_second            <= 1'b0;
			first_lost               <= 1'b0;
			second_lost              <= 1'b0;
			phase_locked             <= 1'b0;
			reference_choice_pin_out <= 1'b0;
			reference_choice_pin_oe  <= 1'b0;
			holdover_pin_out         <= 1'b0;
			holdover_pin_oe          <= 1'b0;
		end
		else
		begin
			in_holdover              <= (state == ST_HOLD);
			active_second            <= sel;
			first_lost               <= lost_a;
			second_lost              <= lost_b;
			phase_locked             <= (lock_cnt == 16'hFFFF);
			reference_choice_pin_out <= sel; // [RL15]
			reference_choice_pin_oe  <= auto_switch_mode; // [RL15]
			holdover_pin_out         <= (state == ST_HOLD); // [RL16]
			holdover_pin_oe          <= auto_holdover_mode; // [RL16]
		end
	end
endmodule : digital_loop_core

//--- sim/ref_pair.sv
// two stoppable reference clock sources for the loop core
`timescale 1ns/100ps
module ref_pair
#(
	parameter real HALF_FIRST  = 200.0,
	parameter real HALF_SECOND = 200.0
)
(
	input  wire logic run_first,
	input  wire logic run_second,
	output logic      ref_first,
	output logic      ref_second
);
	initial ref_first = 1'b0;
	initial ref_second = 1'b0;
	// a stopped source stands still, which is how a lost reference looks
	always #(HALF_FIRST) if (run_first) ref_first = ~ref_first;
	always #(HALF_SECOND) if (run_second) ref_second = ~ref_second;
endmodule : ref_pair

//--- sim/dpll_core_asserts.sv
// port checks for the loop core
`timescale 1ns/100ps
module dpll_core_asserts
(
	input  wire logic                       sys_clk,
	input  wire logic                       nrst,
	input  wire logic                       ref_input_first,
	input  wire logic                       reference_choice_pin_in,
	input  wire logic                       reference_choice_pin_out,
	input  wire logic                       reference_choice_pin_oe,
	input  wire logic                       holdover_pin_in,
	input  wire logic                       holdover_pin_out,
	input  wire logic                       holdover_pin_oe,
	input  wire logic                       auto_switch_mode,
	input  wire logic                       auto_holdover_mode,
	input  wire logic [dpll_pkg::FTW_W-1:0] tuning_word,
	input  wire logic [dpll_pkg::DAC_W-1:0] dac_code,
	input  wire logic                       in_holdover,
	input  wire logic                       active_second,
	input  wire logic                       first_lost,
	input  wire logic                       second_lost
);
	import dpll_pkg::*;
	logic        live;
	logic        first_d;
	logic [15:0] quiet;
	////////////////////////////////////////////////////////////////
	// live masks the first edge, where past values come from reset
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
			live <= 1'b0;
		else
			live <= 1'b1;
	// cycles since the first reference last moved, saturating
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			first_d <= 1'b0;
			quiet   <= 16'h0000;
		end
		else
		begin
			first_d <= ref_input_first;
			if (ref_input_first != first_d)
				quiet <= 16'h0000;
			else if (quiet != 16'hFFFF)
				quiet <= quiet + 16'h0001;
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence both_lost_s;
		(auto_holdover_mode && first_lost && second_lost)[*3];
	endsequence
	sequence held_s;
		in_holdover[*3];
	endsequence
	sequence man_sel_s;
		(live && !auto_switch_mode && $stable(reference_choice_pin_in))[*3];
	endsequence
	AST_SEL_OE: assert property (live |-> reference_choice_pin_oe == $past(auto_switch_mode))
		else $error("select pin enable does not follow switch mode");
	AST_HOLD_OE: assert property (live |-> holdover_pin_oe == $past(auto_holdover_mode))
		else $error("holdover pin enable does not follow holdover mode");
	AST_SEL_OUT: assert property (reference_choice_pin_oe |-> reference_choice_pin_out == active_second)
		else $error("select pin does not show active reference");
	AST_HOLD_OUT: assert property (holdover_pin_oe |-> holdover_pin_out == in_holdover)
		else $error("holdover pin does not show holdover");
	AST_MAN_SEL: assert property (man_sel_s |-> active_second == reference_choice_pin_in)
		else $error("manual select not obeyed");
	AST_MAN_HOLD: assert property ((live && !auto_holdover_mode && holdover_pin_in)[*3] |-> in_holdover)
		else $error("manual holdover not entered");
	AST_FREEZE: assert property (held_s |-> $stable(tuning_word))
		else $error("tuning word moves in holdover");
	AST_DDS: assert property (live && tuning_word[31:16] != 16'h0000 |-> ##[1:8] $changed(dac_code))
		else $error("synthesizer output stands still");
	AST_LOSS: assert property (quiet > MISS_LIMIT + 16'h0020 |-> first_lost)
		else $error("silent reference not flagged lost");
	AST_AUTO_HOLD: assert property (both_lost_s |-> in_holdover)
		else $error("no holdover with both references lost");
endmodule : dpll_core_asserts

//--- sim/digital_pll_core_holdover_tb_top.sv
// self-checking bench for the loop core
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("Error t=%0t got=%0h exp=%0h", $time, g, e); end end
module digital_pll_core_holdover_tb_top;
	import dpll_pkg::*;
	logic              sys_clk, nrst, run_first, run_second, sel_drive, hold_drive;
	logic              ref_input_first, ref_input_second, feedback_clock_input;
	logic              reference_choice_pin_in, reference_choice_pin_out, reference_choice_pin_oe;
	logic              holdover_pin_in, holdover_pin_out, holdover_pin_oe;
	logic              auto_switch_mode, auto_holdover_mode, estimator_enable;
	logic              in_holdover, active_second, first_lost, second_lost, phase_locked;
	logic [DIV_W-1:0]  r_div_m1, s_div_m1;
	logic [COEF_W-1:0] coef_prop, coef_integ;
	logic [FTW_W-1:0]  ftw_nominal, tuning_word, hold_word;
	logic [DAC_W-1:0]  dac_code, dac_seen;
	int                failures, cmp_count;
	////////////////////////////////////////////////////////////////
	ref_pair u_src (.run_first(run_first), .run_second(run_second), .ref_first(ref_input_first),
		.ref_second(ref_input_second));
	digital_loop_core dut
	(
		.sys_clk                  (sys_clk),
		.nrst                     (nrst),
		.ref_input_first          (ref_input_first),
		.ref_input_second         (ref_input_second),
		.feedback_clock_input     (feedback_clock_input),
		.reference_choice_pin_in  (reference_choice_pin_in),
		.reference_choice_pin_out (reference_choice_pin_out),
		.reference_choice_pin_oe  (reference_choice_pin_oe),
		.holdover_pin_in          (holdover_pin_in),
		.holdover_pin_out         (holdover_pin_out),
		.holdover_pin_oe          (holdover_pin_oe),
		.auto_switch_mode         (auto_switch_mode),
		.auto_holdover_mode       (auto_holdover_mode),
		.estimator_enable         (estimator_enable),
		.r_div_m1                 (r_div_m1),
		.s_div_m1                 (s_div_m1),
		.coef_prop                (coef_prop),
		.coef_integ               (coef_integ),
		.ftw_nominal              (ftw_nominal),
		.tuning_word              (tuning_word),
		.dac_code                 (dac_code),
		.in_holdover              (in_holdover),
		.active_second            (active_second),
		.first_lost               (first_lost),
		.second_lost              (second_lost),
		.phase_locked             (phase_locked)
	);
	// the top bit of the dac code comes back as the feedback clock
	assign feedback_clock_input = dac_code[DAC_W-1];
	// shared pins: whoever enables drives the wire
	assign reference_choice_pin_in = reference_choice_pin_oe ? reference_choice_pin_out : sel_drive;
	assign holdover_pin_in = holdover_pin_oe ? holdover_pin_out : hold_drive;
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	task automatic t_manual_sel;
		for (int v = 1; v >= 0; v--)
		begin
			sel_drive = v[0];
			step(4);
			`CHK(active_second, v[0])
			`CHK(reference_choice_pin_oe, 1'b0)
		end
	endtask : t_manual_sel
	task automatic t_manual_hold;
		hold_drive = 1'b1;
		step(4);
		`CHK(in_holdover, 1'b1)
		`CHK(holdover_pin_oe, 1'b0)
		hold_word = tuning_word;
		`CHK((hold_word > 32'h1999_899A) && (hold_word < 32'h1999_A99A), 1'b1)
		step(200);
		`CHK(tuning_word, hold_word)
		dac_seen = dac_code;
		step(3);
		`CHK(dac_code !== dac_seen, 1'b1)
		hold_drive = 1'b0;
		step(4);
		`CHK(in_holdover, 1'b0)
	endtask : t_manual_hold
	task automatic t_auto_hold;
		auto_holdover_mode = 1'b1;
		step(3);
		`CHK(holdover_pin_oe, 1'b1)
		run_first = 1'b0;
		run_second = 1'b0;
		step(MISS_LIMIT + 100);
		`CHK({first_lost, second_lost}, 2'b11)
		`CHK(holdover_pin_out, 1'b1)
		run_first = 1'b1;
		run_second = 1'b1;
		step(500);
		`CHK({first_lost, in_holdover}, 2'b00)
	endtask : t_auto_hold
	task automatic t_auto_switch;
		auto_switch_mode = 1'b1;
		step(3);
		`CHK(reference_choice_pin_oe, 1'b1)
		run_first = 1'b0;
		step(MISS_LIMIT + 100);
		`CHK(active_second, 1'b1)
		`CHK(reference_choice_pin_out, 1'b1)
		`CHK(in_holdover, 1'b0)
		run_first = 1'b1;
		step(500);
	endtask : t_auto_switch
	// second reset with the estimator on; start word far from the true one
	task automatic t_estimate;
		estimator_enable = 1'b1;
		ftw_nominal = 32'h0800_0000;
		nrst = 1'b0;
		step(4);
		nrst = 1'b1;
		step(65002);
		`CHK(tuning_word, 32'h0800_0000)
		step(545);
		`CHK((tuning_word > 32'h1995_999A) && (tuning_word < 32'h199D_999A), 1'b1)
		`CHK(phase_locked, 1'b0)
	endtask : t_estimate
	////////////////////////////////////////////////////////////////
	initial
	begin
		failures = 0;
		cmp_count = 0;
		nrst = 1'b0;
		run_first = 1'b1;
		run_second = 1'b1;
		sel_drive = 1'b0;
		hold_drive = 1'b0;
		auto_switch_mode = 1'b0;
		auto_holdover_mode = 1'b0;
		estimator_enable = 1'b0;
		r_div_m1 = 16'h0000;
		s_div_m1 = 16'h0003;
		coef_prop = 16'h0100;
		coef_integ = 16'h0010;
		ftw_nominal = 32'h1999_999A; // tenth of sample rate, well under the ceiling
		step(4);
		`CHK(tuning_word, FTW_RESET)
		nrst = 1'b1;
		step(1000);
		t_manual_sel();
		t_manual_hold();
		t_auto_hold();
		t_auto_switch();
		t_estimate();
		report_and_stop();
	end
	// whole run is near seventy-six thousand cycles, mostly the estimator window
	initial
	begin
		#900000;
		failures++;
		report_and_stop();
	end
endmodule : digital_pll_core_holdover_tb_top
////////////////////////////////////////////////////////////////
bind digital_loop_core dpll_core_asserts u_chk
(
	.sys_clk                  (sys_clk),
	.nrst                     (nrst),
	.ref_input_first          (ref_input_first),
	.reference_choice_pin_in  (reference_choice_pin_in),
	.reference_choice_pin_out (reference_choice_pin_out),
	.reference_choice_pin_oe  (reference_choice_pin_oe),
	.holdover_pin_in          (holdover_pin_in),
	.holdover_pin_out         (holdover_pin_out),
	.holdover_pin_oe          (holdover_pin_oe),
	.auto_switch_mode         (auto_switch_mode),
	.auto_holdover_mode       (auto_holdover_mode),
	.tuning_word              (tuning_word),
	.dac_code                 (dac_code),
	.in_holdover              (in_holdover),
	.active_second            (active_second),
	.first_lost               (first_lost),
	.second_lost              (second_lost)
);
